//--- src/svw_pkg.sv
// Purpose: Shared constants for the supervisor watchdog reset block.
// Assumes: A 125 MHz system clock.
// Notes:   Times are given in their own unit; cycle counts derive from them.
package svw_pkg;

  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned RST_PULSE_MS = 200;
  localparam int unsigned WDOG_MS      = 1600;
  localparam int unsigned RST_CYCLES   = (CLK_HZ / 1000) * RST_PULSE_MS;
  localparam int unsigned WDOG_CYCLES  = (CLK_HZ / 1000) * WDOG_MS;
  localparam int unsigned CNT_W        = 32;

  typedef enum logic [1:0] {
    SVW_RST_HOLD,
    SVW_RST_STRETCH,
    SVW_RST_IDLE
  } svw_rst_state_t;

endpackage : svw_pkg

//--- src/svw_timer.sv
// Purpose: Restartable up counter that flags when a terminal count is reached.
// Assumes: Synchronous active-high reset.
// Notes:   The count saturates at the terminal value until cleared.
module svw_timer
  import svw_pkg::*;
#(
  parameter logic [CNT_W-1:0] LIMIT = 32'h0000_0001
)
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_clear,
  input  wire logic             i_run,
  output logic                  o_done
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (i_clear)
    begin
      cnt_d = '0;
    end
    else if (i_run && (cnt_q != LIMIT))
    begin
      cnt_d = cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign o_done = (cnt_q == LIMIT);

endmodule // svw_timer

//--- src/svw_supervisor.sv
// Purpose: Reset generator, independent watchdog and power-fail flag.
// Assumes: Analog comparisons arrive as synchronous digital levels.
// Notes:   Long times are parameters so a simulation can shorten them.
module svw_supervisor
  import svw_pkg::*;
#(
  parameter int unsigned RST_CNT  = RST_CYCLES,
  parameter int unsigned WDOG_CNT = WDOG_CYCLES
)
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_manual_reset_req_n,
  input  wire logic i_supply_low,
  input  wire logic i_powerfail_sense_low,
  input  wire logic i_watchdog_kick_in,
  input  wire logic i_watchdog_kick_hiz,
  output logic      o_reset_n,
  output logic      o_watchdog_expired_n,
  output logic      o_powerfail_flag_n
);

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  svw_rst_state_t state_q;
  svw_rst_state_t state_d;
  logic           rst_n_q;
  logic           rst_n_d;
  logic           hold;
  logic           stretch_done;

  // The pad pull-up makes an open pin read high at this port.
  assign hold = i_supply_low || !i_manual_reset_req_n;

  // The stretch only counts while no hold is present; a hold sends the
  // sequencer back to its hold state, which clears the count.
  svw_timer #(
    .LIMIT (CNT_W'(RST_CNT - 1))
  ) u_rst_timer (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_clear (state_q != SVW_RST_STRETCH),
    .i_run   (!hold),
    .o_done  (stretch_done)
  );

  always_comb
  begin
    state_d = state_q;
    rst_n_d = 1'b0;
    case (state_q)
      SVW_RST_HOLD:
      begin
        if (!hold)
        begin
          state_d = SVW_RST_STRETCH;
        end
      end
      SVW_RST_STRETCH:
      begin
        if (hold)
        begin
          state_d = SVW_RST_HOLD;
        end
        else if (stretch_done)
        begin
          state_d = SVW_RST_IDLE;
          rst_n_d = 1'b1;
        end
      end
      SVW_RST_IDLE:
      begin
        rst_n_d = 1'b1;
        // Watchdog expiry is deliberately not a trigger here.
        if (hold)
        begin
          state_d = SVW_RST_HOLD;
          rst_n_d = 1'b0;
        end
      end
      default:
      begin
        state_d = SVW_RST_HOLD;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q <= SVW_RST_HOLD;
      rst_n_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      rst_n_q <= rst_n_d;
    end
  end

  assign o_reset_n = rst_n_q;

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  logic kick_q;
  logic kick_d;
  logic wd_n_q;
  logic wd_n_d;
  logic wd_pf_q;
  logic wd_pf_d;
  logic wd_clear;
  logic wd_done;

  // Edges are taken on the registered level, which keeps following the
  // pin through three-state, so release does not fake an edge.
  assign wd_clear = !rst_n_q || i_watchdog_kick_hiz
                    || (i_watchdog_kick_in != kick_q);

  svw_timer #(
    .LIMIT (CNT_W'(WDOG_CNT - 1))
  ) u_wd_timer (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_clear (wd_clear),
    .i_run   (!i_watchdog_kick_hiz),
    .o_done  (wd_done)
  );

  always_comb
  begin
    kick_d  = i_watchdog_kick_in;
    wd_n_d  = wd_n_q;
    wd_pf_d = !i_powerfail_sense_low;
    if (i_supply_low)
    begin
      wd_n_d = 1'b0;
    end
    else if (wd_clear)
    begin
      wd_n_d = 1'b1;
    end
    else if (wd_done)
    begin
      wd_n_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      kick_q  <= 1'b0;
      wd_n_q  <= 1'b1;
      wd_pf_q <= 1'b1;
    end
    else
    begin
      kick_q  <= kick_d;
      wd_n_q  <= wd_n_d;
      wd_pf_q <= wd_pf_d;
    end
  end

  assign o_watchdog_expired_n = wd_n_q;
  assign o_powerfail_flag_n   = wd_pf_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_hold_seen;
    hold;
  endsequence

  sequence s_reset_low;
    !o_reset_n;
  endsequence

  reset_on_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_hold_seen |=> s_reset_low)
    else $error("Reset not low after manual request or low supply.");

  supply_holds_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_supply_low ##1 i_supply_low |-> !o_reset_n)
    else $error("Reset released while supply low.");

  stretch_min_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(hold) |-> !o_reset_n [*8])
    else $error("Reset released too soon after hold ended.");

  // Reset-low cycles since the last hold, counted apart from the
  // sequencer's timer so that a miscounted stretch cannot hide.
  logic [CNT_W-1:0] low_run_q;
  logic [CNT_W-1:0] low_run_d;

  always_comb
  begin
    low_run_d = low_run_q;
    if (hold || o_reset_n)
    begin
      low_run_d = '0;
    end
    else if (low_run_q != '1)
    begin
      low_run_d = low_run_q + CNT_W'(32'h0000_0001);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      low_run_q <= '0;
    end
    else
    begin
      low_run_q <= low_run_d;
    end
  end

  pulse_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_reset_n) |-> ((low_run_q >= CNT_W'(RST_CNT))
    && (low_run_q <= CNT_W'(RST_CNT + 1))))
    else $error("Reset stretch length differs from its count.");

  wd_no_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!o_watchdog_expired_n && o_reset_n && !hold) |=> o_reset_n)
    else $error("Watchdog expiry asserted reset.");

  pf_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> (o_powerfail_flag_n == !$past(i_powerfail_sense_low)))
    else $error("Power-fail flag does not follow sense input.");

  wd_expire_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (wd_done && !wd_clear && !i_supply_low) |=> !o_watchdog_expired_n)
    else $error("Watchdog did not expire at terminal count.");

  wd_hiz_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_watchdog_kick_hiz && !i_supply_low) |=> o_watchdog_expired_n)
    else $error("Watchdog active while kick input three-stated.");

  wd_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!o_watchdog_expired_n && !wd_clear && !i_supply_low)
    |=> !o_watchdog_expired_n)
    else $error("Expired output released without a clear.");

  wd_low_line_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_supply_low |=> !o_watchdog_expired_n)
    else $error("Expired output high during low supply.");

  wd_recover_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(i_supply_low) |=> o_watchdog_expired_n)
    else $error("Expired output delayed after supply recovery.");

endmodule // svw_supervisor

//--- test/svw_host_model.sv
// Purpose: Host model that kicks the watchdog or lets its pin float.
// Assumes: While enabled the kick toggles every clock.
// Notes:   On release the pin settles at the inverse of its last level.
module svw_host_model
(
  input  wire logic i_clk,
  input  wire logic i_kick_en,
  input  wire logic i_float,
  output logic      o_kick,
  output logic      o_kick_hiz
);
  timeunit 1ns;
  timeprecision 1ns;
  logic float_q = 1'b0;
  initial o_kick = 1'b0;
  assign o_kick_hiz = i_float;
  // A held level after release would hide a missing three-state check.
  always @(posedge i_clk)
  begin
    if (i_kick_en || (i_float && !float_q))
      o_kick <= ~o_kick;
    float_q <= i_float;
  end
endmodule // svw_host_model

//--- test/supervisor_watchdog_reset_bench.sv
// Purpose: Self-checking bench for the supervisor block.
// Assumes: Shortened counts so the run stays brief.
// Notes:   Stretch figures allow a cycle or two of slack.
module supervisor_watchdog_reset_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC = 20;
  localparam int WC = 50;
  logic clk     = 1'b0;
  logic rst     = 1'b1;
  logic mr_n    = 1'b1;
  logic sup_low = 1'b0;
  logic pf_low  = 1'b0;
  logic kick_en = 1'b1;
  logic flt     = 1'b0;
  logic kick;
  logic hiz;
  logic reset_n;
  logic wdo_n;
  logic pfo_n;
  int   err_count = 0;
  int   checks = 0;
  always #4 clk = ~clk;
  svw_host_model i_host (.i_clk(clk), .i_kick_en(kick_en), .i_float(flt),
    .o_kick(kick), .o_kick_hiz(hiz));
  svw_supervisor #(.RST_CNT(RC), .WDOG_CNT(WC)) i_dut (.i_clk(clk),
    .i_rst(rst), .i_manual_reset_req_n(mr_n), .i_supply_low(sup_low),
    .i_powerfail_sense_low(pf_low), .i_watchdog_kick_in(kick),
    .i_watchdog_kick_hiz(hiz), .o_reset_n(reset_n),
    .o_watchdog_expired_n(wdo_n), .o_powerfail_flag_n(pfo_n));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic seen, input logic exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_lvl(input bit use_wdo, input logic v, input int lim,
                          output int n);
    logic s;
    n = 0;
    s = use_wdo ? wdo_n : reset_n;
    while (s !== v)
    begin
      if (n == lim)
      begin
        err_count++;
        $display("CHECK FAILED wait expected %b seen %b", v, s);
        give_verdict();
      end
      tick(1);
      n++;
      s = use_wdo ? wdo_n : reset_n;
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_powerfail();
    @(posedge clk);
    pf_low <= 1'b1;
    tick(1);
    check("pfo_n", pfo_n, 1'b0);
    @(posedge clk);
    pf_low <= 1'b0;
    tick(1);
    check("pfo_n", pfo_n, 1'b1);
  endtask
  task automatic t_manual();
    int n;
    @(posedge clk);
    mr_n <= 1'b0;
    tick(1);
    check("reset_n", reset_n, 1'b0);
    tick(2 * RC);
    check("reset_n", reset_n, 1'b0);
    @(posedge clk);
    mr_n <= 1'b1;
    wait_lvl(1'b0, 1'b1, RC + 3, n);
    check("stretch", n >= RC - 1, 1'b1);
  endtask
  task automatic t_watchdog();
    int n;
    @(posedge clk);
    kick_en <= 1'b0;
    wait_lvl(1'b1, 1'b0, WC + 3, n);
    check("expiry", n >= WC - 2, 1'b1);
    tick(8);
    check("wdo_n", wdo_n, 1'b0);
    check("reset_n", reset_n, 1'b1);
    @(posedge clk);
    kick_en <= 1'b1;
    tick(3);
    check("wdo_n", wdo_n, 1'b1);
  endtask
  task automatic t_float();
    int lows;
    lows = 0;
    @(posedge clk);
    kick_en <= 1'b0;
    flt <= 1'b1;
    repeat (2 * WC)
    begin
      tick(1);
      lows += int'(wdo_n !== 1'b1);
    end
    check("wdo_n", lows == 0, 1'b1);
    @(posedge clk);
    flt <= 1'b0;
    kick_en <= 1'b1;
  endtask
  task automatic t_supply();
    int n;
    @(posedge clk);
    sup_low <= 1'b1;
    tick(1);
    check("wdo_n", wdo_n, 1'b0);
    tick(2 * RC);
    check("reset_n", reset_n, 1'b0);
    @(posedge clk);
    sup_low <= 1'b0;
    tick(1);
    check("wdo_n", wdo_n, 1'b1);
    wait_lvl(1'b0, 1'b1, RC + 3, n);
    check("stretch", n >= RC - 2, 1'b1);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    int n;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_lvl(1'b0, 1'b1, RC + 4, n);
    check("pfo_n", pfo_n, 1'b1);
    t_powerfail();
    t_manual();
    t_watchdog();
    t_float();
    t_supply();
    give_verdict();
  end
endmodule // supervisor_watchdog_reset_bench
